// ### sfm_top.sv
`timescale 1ns/100ps
`include "sfm_map.svh"
module sfm_top (
  input  wire logic                  aclk,
  input  wire logic                  aresetn,
  input  wire logic                  s_axi_awvalid,
  output wire logic                  s_axi_awready,
  input  wire logic [7:0]            s_axi_awaddr,
  input  wire logic [2:0]            s_axi_awprot,
  input  wire logic                  s_axi_wvalid,
  output wire logic                  s_axi_wready,
  input  wire logic [31:0]           s_axi_wdata,
  input  wire logic [3:0]            s_axi_wstrb,
  output wire logic                  s_axi_bvalid,
  input  wire logic                  s_axi_bready,
  output wire logic [1:0]            s_axi_bresp,
  input  wire logic                  s_axi_arvalid,
  output wire logic                  s_axi_arready,
  input  wire logic [7:0]            s_axi_araddr,
  input  wire logic [2:0]            s_axi_arprot,
  output wire logic                  s_axi_rvalid,
  input  wire logic                  s_axi_rready,
  output wire logic [31:0]           s_axi_rdata,
  output wire logic [1:0]            s_axi_rresp,
  input  wire sfm_pkg::sfm_alarm_type alarm_async,
  input  wire logic                  nvm_light_async,
  input  wire sfm_pkg::sfm_mode_type cpu_mode,
  input  wire logic [4:0]            fault_det,
  input  wire logic [7:0]            sp_cur,
  input  wire logic                  nvm_ecc_err,
  input  wire logic                  nvm_ecc_fix,
  input  wire logic                  rom_par_err,
  input  wire logic                  nvm_wr_act,
  input  wire logic                  hv_ok,
  output wire logic                  chip_rst_req,
  output wire logic                  exc_req,
  output wire logic                  exc_pend,
  output wire logic                  sensor_en,
  output wire logic [1:0]            nvm_light_sel,
  output wire logic                  ecc_inv_en
);

  sfm_pkg::sfm_state_type q;
  sfm_pkg::sfm_state_type n;

  logic       sens_on;
  logic [4:0] rst_ev;
  logic [7:0] exc_ev;
  logic [7:0] lim_act;
  logic       aw_hs;
  logic       w_hs;
  logic       ar_hs;
  logic       wr_go;
  logic       wr_ok;
  logic [7:0] wb;

  // Mode group: user, system, super system
  function automatic logic [1:0] mode_grp(input sfm_pkg::sfm_mode_type m);
    case (m)
      sfm_pkg::MODE_USER:   mode_grp = 2'h0;
      sfm_pkg::MODE_SYSTEM: mode_grp = 2'h1;
      default:              mode_grp = 2'h2;
    endcase
  endfunction

  // Address decode
  function automatic logic is_mapped(input logic [7:0] a);
    case (a)
      `SFM_OFS_CAUSE,
      `SFM_OFS_REASON,
      `SFM_OFS_CTRL,
      `SFM_OFS_STATUS,
      `SFM_OFS_LIM_USR,
      `SFM_OFS_LIM_SYS,
      `SFM_OFS_LIM_SSM: is_mapped = 1'b1;
      default:          is_mapped = 1'b0;
    endcase
  endfunction

  // Read data mux
  function automatic logic [31:0] rd_val(
    input logic [7:0]             a,
    input sfm_pkg::sfm_state_type s,
    input logic                   son
  );
    logic [31:0] v;
    v = 32'h0000_0000;
    case (a)
      `SFM_OFS_CAUSE:   v[4:0] = s.cause;
      `SFM_OFS_REASON:  v[7:0] = s.reason;
      `SFM_OFS_CTRL: begin
        v[`SFM_CTRL_INV]  = s.inv_ecc;
        v[`SFM_CTRL_LSEL] = s.lsel;
      end
      `SFM_OFS_STATUS: begin
        v[`SFM_STS_HVFAIL] = s.hv_fail;
        v[`SFM_STS_HVDONE] = s.hv_done;
        v[`SFM_STS_SENSON] = son;
        v[`SFM_STS_EXCP]   = s.exc_p;
        v[`SFM_STS_INRST]  = s.rst_o;
      end
      `SFM_OFS_LIM_USR: v[7:0] = s.lim[0];
      `SFM_OFS_LIM_SYS: v[7:0] = s.lim[1];
      `SFM_OFS_LIM_SSM: v[7:0] = s.lim[2];
      default:          v = 32'h0000_0000;
    endcase
    rd_val = v;
  endfunction

  always_comb begin
    n = q;
    n.exc_o = 1'b0;

    // Two-stage alarm synchroniser
    n.s1 = {nvm_light_async, alarm_async};
    n.s2 = q.s1;

    // Sensors forced on outside test mode
    sens_on = (cpu_mode != sfm_pkg::MODE_TEST);

    // Reset-class events, fixed wiring
    rst_ev[3:0] = sens_on ? q.s2[3:0] : 4'h0;
    rst_ev[4]   = rom_par_err;

    // Active stack limit copy
    lim_act = q.lim[mode_grp(cpu_mode)];

    // Exception-class events, fixed wiring
    exc_ev[0]   = sens_on & q.s2[4] & (q.lsel != `SFM_LSEL_OFF);
    exc_ev[5:1] = fault_det;
    exc_ev[6]   = q.inv_ecc & nvm_ecc_err;
    exc_ev[7]   = (sp_cur >= lim_act);

    // Handshakes
    aw_hs = s_axi_awvalid & q.awready;
    w_hs  = s_axi_wvalid & q.wready;
    ar_hs = s_axi_arvalid & q.arready;
    wr_go = q.awv & q.wv & ~q.bvalid;
    wr_ok = wr_go & is_mapped(q.awa) & q.ws[0];
    wb    = q.wd[7:0];

    // Write address and data, either order
    if (aw_hs) begin
      n.awv = 1'b1;
      n.awa = s_axi_awaddr;
    end
    if (w_hs) begin
      n.wv = 1'b1;
      n.wd = s_axi_wdata;
      n.ws = s_axi_wstrb;
    end

    // Register writes
    if (wr_go) begin
      n.awv    = 1'b0;
      n.wv     = 1'b0;
      n.bvalid = 1'b1;
      n.bresp  = is_mapped(q.awa) ? `SFM_RESP_OK : `SFM_RESP_ERR;
    end
    if (wr_ok) begin
      case (q.awa)
        `SFM_OFS_CAUSE:  n.cause  = q.cause & ~wb[4:0];
        `SFM_OFS_REASON: n.reason = q.reason & ~wb;
        `SFM_OFS_CTRL: begin
          n.inv_ecc = wb[`SFM_CTRL_INV];
          // Undefined selection code falls back to off
          if (wb[`SFM_CTRL_LSEL] <= `SFM_LSEL_MAX) begin
            n.lsel = wb[`SFM_CTRL_LSEL];
          end else begin
            n.lsel = `SFM_LSEL_OFF;
          end
          // Sensor-off bit has no storage and no effect
        end
        `SFM_OFS_STATUS: begin
          if (wb[`SFM_STS_HVFAIL]) begin
            n.hv_fail = 1'b0;
          end
          if (wb[`SFM_STS_HVDONE]) begin
            n.hv_done = 1'b0;
          end
        end
        `SFM_OFS_LIM_USR: n.lim[0] = wb;
        `SFM_OFS_LIM_SYS: n.lim[1] = wb;
        `SFM_OFS_LIM_SSM: n.lim[2] = wb;
        default: n.lim = q.lim;
      endcase
    end
    if (q.bvalid & s_axi_bready) begin
      n.bvalid = 1'b0;
    end

    // Read channel
    if (ar_hs) begin
      n.rvalid = 1'b1;
      n.rdata  = rd_val(s_axi_araddr, q, sens_on);
      n.rresp  = is_mapped(s_axi_araddr) ? `SFM_RESP_OK : `SFM_RESP_ERR;
    end
    if (q.rvalid & s_axi_rready) begin
      n.rvalid = 1'b0;
    end

    // High-voltage check during memory write, status only
    if (nvm_wr_act) begin
      n.hv_done = 1'b1;
      if (!hv_ok) begin
        n.hv_fail = 1'b1;
      end
    end

    // Corrected single-bit reads raise nothing
    if (nvm_ecc_fix & ~q.inv_ecc) begin
      n.exc_o = 1'b0;
    end

    // Exception reason, set wins over clear
    n.reason = n.reason | exc_ev;
    n.exc_o  = |(exc_ev & ~q.reason);
    n.exc_p  = |n.reason;

    // Reset cause, set wins over clear
    case (q.st)
      sfm_pkg::ST_RUN: begin
        if (|rst_ev) begin
          n.st    = sfm_pkg::ST_HOLD;
          n.cnt   = 8'(`SFM_RST_CYC);
          n.rst_o = 1'b1;
          n.cause = n.cause | rst_ev;
        end
      end
      sfm_pkg::ST_HOLD: begin
        n.rst_o = 1'b1;
        if (q.cnt == 8'h01) begin
          n.st = sfm_pkg::ST_WAIT;
        end else begin
          n.cnt = q.cnt - 8'h01;
        end
      end
      sfm_pkg::ST_WAIT: begin
        if (|rst_ev) begin
          n.cause = n.cause | rst_ev;
        end else begin
          n.st    = sfm_pkg::ST_RUN;
          n.rst_o = 1'b0;
        end
      end
      default: begin
        n.st    = sfm_pkg::ST_RUN;
        n.rst_o = 1'b0;
      end
    endcase

    // Forced reset returns settings to defaults, cause survives
    if (q.st != sfm_pkg::ST_RUN) begin
      n.reason  = 8'h00;
      n.exc_o   = 1'b0;
      n.exc_p   = 1'b0;
      n.inv_ecc = 1'b0;
      n.lsel    = `SFM_LSEL_OFF;
      n.hv_fail = 1'b0;
      n.hv_done = 1'b0;
      n.lim     = {3{`SFM_LIM_RST}};
    end

    // Readies from next state
    n.awready = ~n.awv & ~n.bvalid;
    n.wready  = ~n.wv & ~n.bvalid;
    n.arready = ~n.rvalid;
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      q     <= '0;
      q.lim <= {3{`SFM_LIM_RST}};
    end else begin
      q <= n;
    end
  end

  // Sensor enable flop
  logic sens_q;
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      sens_q <= 1'b1;
    end else begin
      sens_q <= sens_on;
    end
  end

  assign s_axi_awready = q.awready;
  assign s_axi_wready  = q.wready;
  assign s_axi_bvalid  = q.bvalid;
  assign s_axi_bresp   = q.bresp;
  assign s_axi_arready = q.arready;
  assign s_axi_rvalid  = q.rvalid;
  assign s_axi_rdata   = q.rdata;
  assign s_axi_rresp   = q.rresp;
  assign chip_rst_req  = q.rst_o;
  assign exc_req       = q.exc_o;
  assign exc_pend      = q.exc_p;
  assign sensor_en     = sens_q;
  assign nvm_light_sel = q.lsel;
  assign ecc_inv_en    = q.inv_ecc;

endmodule

// ### sfm_map.svh
`ifndef SFM_MAP_SVH
`define SFM_MAP_SVH
// Register byte offsets
`define SFM_OFS_CAUSE   8'h00
`define SFM_OFS_REASON  8'h04
`define SFM_OFS_CTRL    8'h08
`define SFM_OFS_STATUS  8'h0C
`define SFM_OFS_LIM_USR 8'h10
`define SFM_OFS_LIM_SYS 8'h14
`define SFM_OFS_LIM_SSM 8'h18
// Control fields
`define SFM_CTRL_INV    0
`define SFM_CTRL_LSEL   2:1
`define SFM_CTRL_SOFF   3
// Status fields
`define SFM_STS_HVFAIL  0
`define SFM_STS_HVDONE  1
`define SFM_STS_SENSON  2
`define SFM_STS_EXCP    3
`define SFM_STS_INRST   4
// Light selection codes
`define SFM_LSEL_OFF    2'h0
`define SFM_LSEL_MAX    2'h2
// Reset values
`define SFM_LIM_RST     8'hFF
// Bus responses
`define SFM_RESP_OK     2'h0
`define SFM_RESP_ERR    2'h2
// Timing
`define SFM_CLK_NS      4
`define SFM_RST_NS      100
`define SFM_RST_CYC     ((`SFM_RST_NS + `SFM_CLK_NS - 1) / `SFM_CLK_NS)
`endif

// ### sfm_pkg.sv
package sfm_pkg;
  typedef enum logic [2:0] {
    MODE_USER   = 3'h0,
    MODE_SYSTEM = 3'h1,
    MODE_BOOT   = 3'h2,
    MODE_TEST   = 3'h3,
    MODE_CLESS  = 3'h4
  } sfm_mode_type;
  typedef enum logic [1:0] {
    ST_RUN  = 2'h0,
    ST_HOLD = 2'h1,
    ST_WAIT = 2'h3
  } sfm_st_type;
  typedef struct packed {
    logic volt;
    logic freq;
    logic temp;
    logic light;
  } sfm_alarm_type;
  typedef struct packed {
    logic [4:0]      s1;
    logic [4:0]      s2;
    sfm_st_type      st;
    logic [7:0]      cnt;
    logic            rst_o;
    logic            exc_o;
    logic            exc_p;
    logic [4:0]      cause;
    logic [7:0]      reason;
    logic            inv_ecc;
    logic [1:0]      lsel;
    logic            hv_fail;
    logic            hv_done;
    logic [2:0][7:0] lim;
    logic            awv;
    logic            wv;
    logic [7:0]      awa;
    logic [31:0]     wd;
    logic [3:0]      ws;
    logic            awready;
    logic            wready;
    logic            bvalid;
    logic [1:0]      bresp;
    logic            arready;
    logic            rvalid;
    logic [31:0]     rdata;
    logic [1:0]      rresp;
  } sfm_state_type;
endpackage

// ### sfm_sens.sv
`timescale 1ns/100ps
module sfm_sens (
  input  wire logic [4:0]             req,
  output wire sfm_pkg::sfm_alarm_type alarm_async,
  output wire logic                   nvm_light_async
);
  // Alarm levels land off the clock grid
  assign #1.3 {alarm_async, nvm_light_async} = req;
endmodule

// ### sfm_properties.sv
`timescale 1ns/100ps
module sfm_props (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic rom_par_err,
  input wire logic [4:0] fault_det,
  input wire sfm_pkg::sfm_mode_type cpu_mode,
  input wire logic chip_rst_req,
  input wire logic exc_req,
  input wire logic exc_pend,
  input wire logic sensor_en
);
  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);
  property p_rom;
    rom_par_err |=> chip_rst_req;
  endproperty
  a_rom: assert property (p_rom) else $error("no parity reset");
  property p_hold;
    $rose(chip_rst_req) |=> chip_rst_req [*8];
  endproperty
  a_hold: assert property (p_hold) else $error("reset short");
  property p_quiet;
    chip_rst_req && $past(chip_rst_req) |-> !exc_req;
  endproperty
  a_quiet: assert property (p_quiet) else $error("exception in reset");
  property p_clr;
    chip_rst_req [*3] |-> !exc_pend;
  endproperty
  a_clr: assert property (p_clr) else $error("reason kept");
  property p_fault;
    fault_det != 5'h0 && !chip_rst_req && !rom_par_err |-> ##[1:2] exc_pend;
  endproperty
  a_fault: assert property (p_fault) else $error("fault missed");
  property p_why;
    exc_req |-> ##[0:1] exc_pend;
  endproperty
  a_why: assert property (p_why) else $error("no reason");
  property p_on;
    cpu_mode != sfm_pkg::MODE_TEST |=> sensor_en;
  endproperty
  a_on: assert property (p_on) else $error("sensors off");
  property p_test;
    cpu_mode == sfm_pkg::MODE_TEST |=> !sensor_en;
  endproperty
  a_test: assert property (p_test) else $error("sensors on");
  c_rst: cover property ($rose(chip_rst_req));
  c_exc: cover property (exc_req);
  c_tst: cover property (!sensor_en);
endmodule
bind sfm_top sfm_props u_props (.aclk, .aresetn, .rom_par_err, .fault_det, .cpu_mode,
  .chip_rst_req, .exc_req, .exc_pend, .sensor_en);

// ### tb.sv
`timescale 1ns/100ps
module tb;
  logic aclk, aresetn = '0, chip_rst_req, exc_req, exc_pend, sensor_en, ecc_inv_en;
  logic s_axi_awvalid = '0, s_axi_wvalid = '0, s_axi_bready = '0, s_axi_arvalid = '0;
  logic s_axi_rready = '0, s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
  logic s_axi_rvalid, nvm_light_async, nvm_ecc_err = '0, nvm_ecc_fix = '0, rom_par_err = '0;
  logic nvm_wr_act = '0, hv_ok = '1;
  int m_cause = 0, m_reason = 0, m_ctrl = 0;
  int m_rst[$];
  logic [7:0] s_axi_awaddr = '0, s_axi_araddr = '0, sp_cur = '0, lim;
  logic [31:0] s_axi_wdata = '0, s_axi_rdata, d;
  logic [1:0] s_axi_bresp, s_axi_rresp, nvm_light_sel, l;
  logic [4:0] fault_det = '0, req = '0;
  sfm_pkg::sfm_alarm_type alarm_async;
  sfm_pkg::sfm_mode_type cpu_mode = sfm_pkg::MODE_SYSTEM;
  int total_checks = 0, bad_count = 0, cyc = 0;
  sfm_sens u_sens (.req, .alarm_async, .nvm_light_async);
  sfm_top DUT (.aclk, .aresetn, .s_axi_awvalid, .s_axi_awready, .s_axi_awaddr,
    .s_axi_awprot(3'h0), .s_axi_wvalid, .s_axi_wready, .s_axi_wdata, .s_axi_wstrb(4'hF),
    .s_axi_bvalid, .s_axi_bready, .s_axi_bresp, .s_axi_arvalid, .s_axi_arready,
    .s_axi_araddr, .s_axi_arprot(3'h0), .s_axi_rvalid, .s_axi_rready, .s_axi_rdata,
    .s_axi_rresp, .alarm_async, .nvm_light_async, .cpu_mode, .fault_det, .sp_cur,
    .nvm_ecc_err, .nvm_ecc_fix, .rom_par_err, .nvm_wr_act, .hv_ok,
    .chip_rst_req, .exc_req, .exc_pend, .sensor_en, .nvm_light_sel, .ecc_inv_en);
  initial begin
    aclk = '0;
    forever #2 aclk = ~aclk;
  end
  task automatic final_report;
    $display("checks %0d errors %0d", total_checks, bad_count);
    if (bad_count == 0 && total_checks > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  always @(posedge aclk) begin
    cyc++;
    if (cyc == 20000) begin
      bad_count++;
      final_report;
    end
  end
  task automatic chk(input logic [31:0] s, input logic [31:0] e);
    total_checks++;
    if (s !== e) begin
      bad_count++;
      $display("wrong value at %0t: saw %h expected %h", $time, s, e);
    end
  endtask
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] x,
                     input logic [1:0] e = 2'h0);
    @(posedge aclk);
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= {3{w}};
    {s_axi_arvalid, s_axi_rready} <= {2{!w}};
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata} <= {a, a, x};
    do begin
      @(posedge aclk);
      if (s_axi_awready) s_axi_awvalid <= '0;
      if (s_axi_wready) s_axi_wvalid <= '0;
      if (s_axi_arready) s_axi_arvalid <= '0;
    end while (!(s_axi_bvalid || s_axi_rvalid));
    if (!w) chk(s_axi_rdata, x);
    chk(w ? s_axi_bresp : s_axi_rresp, e);
    {s_axi_bready, s_axi_rready} <= '0;
    if (w && e == 2'h0) begin
      if (a == 8'h00) m_cause = m_cause & ~int'(x[4:0]);
      if (a == 8'h04) m_reason = m_reason & ~int'(x[7:0]);
      if (a == 8'h08) m_ctrl = int'(x[0]) | ((x[2:1] == 2'h3 ? 0 : int'(x[2:1])) << 1);
    end
  endtask
  task automatic ev(input logic [4:0] f, input logic [2:0] x);
    @(posedge aclk);
    fault_det <= f;
    {rom_par_err, nvm_ecc_err, nvm_ecc_fix} <= x;
    m_reason = m_reason | int'({f, 1'b0});
    if (x[1] && m_ctrl[0]) m_reason = m_reason | 32'h40;
    if (x[2]) m_rst.push_back(32'h10);
    @(posedge aclk);
    fault_det <= '0;
    {rom_par_err, nvm_ecc_err, nvm_ecc_fix} <= '0;
    @(posedge aclk);
  endtask
  task automatic wait_rst;
    int n;
    n = 0;
    while (chip_rst_req) begin
      @(posedge aclk);
      n++;
    end
    chk(32'(n >= 25), 32'h1);
    if (m_rst.size() > 0) m_cause = m_cause | m_rst.pop_front();
    m_reason = 0;
    m_ctrl = 0;
    repeat (2) @(posedge aclk);
  endtask
  initial begin
    void'($urandom(32'h8659));
    repeat (4) @(posedge aclk);
    aresetn <= '1;
    for (int i = 0; i < 7; i++)
      bus(1'h0, 8'(4 * i), i < 3 ? 32'h0 : i == 3 ? 32'h4 : 32'hFF);
    bus(1'h0, 8'h1C, 32'h0, 2'h2);
    bus(1'h1, 8'h1C, 32'hFF, 2'h2);
    for (int i = 0; i < 8; i++) begin
      d = $urandom & 32'hFFFF_FFF8 | 32'(i);
      l = d[2:1] == 2'h3 ? 2'h0 : d[2:1];
      bus(1'h1, 8'h08, d);
      bus(1'h0, 8'h08, m_ctrl);
      chk({nvm_light_sel, ecc_inv_en, sensor_en}, {l, d[0], 1'h1});
    end
    for (int i = 0; i < 5; i++) begin
      ev(5'h1 << i, 3'h0);
      chk(exc_req, 1'h1);
      bus(1'h0, 8'h04, m_reason);
      bus(1'h1, 8'h04, 32'hFF);
    end
    bus(1'h1, 8'h08, 32'h0);
    ev(5'h0, 3'h3);
    chk(exc_pend, 1'h0);
    bus(1'h1, 8'h08, 32'h1);
    ev(5'h0, 3'h2);
    bus(1'h0, 8'h04, m_reason);
    bus(1'h1, 8'h04, 32'hFF);
    bus(1'h1, 8'h08, 32'h0);
    req <= 5'h1;
    repeat (6) @(posedge aclk);
    chk(exc_pend, 1'h0);
    bus(1'h1, 8'h08, 32'h2);
    repeat (4) @(posedge aclk);
    chk({chip_rst_req, exc_pend}, 2'h1);
    req <= '0;
    m_reason = m_reason | 32'h1;
    bus(1'h0, 8'h04, m_reason);
    bus(1'h1, 8'h04, 32'hFF);
    nvm_wr_act <= '1;
    hv_ok <= '0;
    repeat (3) @(posedge aclk);
    {nvm_wr_act, hv_ok} <= 2'h1;
    repeat (3) @(posedge aclk);
    chk({chip_rst_req, exc_pend}, 2'h0);
    bus(1'h0, 8'h0C, 32'h7);
    bus(1'h1, 8'h0C, 32'h3);
    bus(1'h0, 8'h0C, 32'h4);
    nvm_wr_act <= '1;
    @(posedge aclk);
    nvm_wr_act <= '0;
    bus(1'h0, 8'h0C, 32'h6);
    for (int i = 0; i < 3; i++) begin
      lim = 8'($urandom_range(200, 20));
      cpu_mode <= sfm_pkg::sfm_mode_type'(i == 2 ? 4 : i);
      bus(1'h1, 8'h10 + 8'(4 * i), {24'h0, lim});
      sp_cur <= lim - 8'h1;
      repeat (3) @(posedge aclk);
      chk(exc_pend, 1'h0);
      sp_cur <= lim;
      repeat (3) @(posedge aclk);
      m_reason = m_reason | 32'h80;
      bus(1'h0, 8'h04, m_reason);
      sp_cur <= '0;
      bus(1'h1, 8'h04, 32'hFF);
      bus(1'h1, 8'h10 + 8'(4 * i), 32'hFF);
    end
    cpu_mode <= sfm_pkg::MODE_SYSTEM;
    for (int i = 0; i < 4; i++) begin
      bus(1'h1, 8'h08, 32'h3);
      req <= 5'h2 << i;
      m_rst.push_back(1 << i);
      while (!chip_rst_req) @(posedge aclk);
      req <= '0;
      wait_rst;
      bus(1'h0, 8'h00, m_cause);
      bus(1'h0, 8'h08, m_ctrl);
      bus(1'h1, 8'h00, 32'h1F);
    end
    ev(5'h0, 3'h4);
    chk(chip_rst_req, 1'h1);
    wait_rst;
    bus(1'h0, 8'h00, m_cause);
    bus(1'h1, 8'h08, 32'h3);
    aresetn <= '0;
    repeat (4) @(posedge aclk);
    chk({s_axi_awready, s_axi_arready, chip_rst_req}, 3'h0);
    aresetn <= '1;
    m_cause = 0;
    m_reason = 0;
    m_ctrl = 0;
    bus(1'h0, 8'h00, m_cause);
    bus(1'h0, 8'h08, m_ctrl);
    cpu_mode <= sfm_pkg::MODE_TEST;
    req <= 5'h10;
    repeat (8) @(posedge aclk);
    chk({sensor_en, chip_rst_req}, 2'h0);
    req <= '0;
    repeat (5) @(posedge aclk);
    cpu_mode <= sfm_pkg::MODE_SYSTEM;
    final_report;
  end
endmodule
